/* File: core/ssd_defs.svh */
// constants of the shift-and-store led sink driver
`ifndef SSD_DEFS_SVH
`define SSD_DEFS_SVH
`define SSD_STAGES 8
`define SSD_PENULT_POS 6
`define SSD_LAST_POS 7
`define SSD_SYNC_DEPTH 3
`endif

/* File: core/ssd_pkg.sv */
// types of the shift-and-store led sink driver
`include "ssd_defs.svh"
package ssd_pkg;
    typedef struct packed {
        logic serial_in;
        logic shift_clock;
        logic latch_strobe;
        logic output_enable;
    } ssd_pins_t;
    typedef struct packed {
        logic [`SSD_STAGES-1:0] o;
        logic [`SSD_STAGES-1:0] oe_n;
    } ssd_sink_t;
endpackage

/* File: core/ssd_driver.sv */
// shift-and-store led sink driver, sampled on clk_sys
// Summary of operation
// (RULE1) each shift clock rise moves eight stages along, serial input entering stage zero
// (RULE2) strobe high makes latches follow stages; strobe low holds them
// (RULE3) output enable low turns every parallel output off
// (RULE4) outputs are inverting open drain: latched one pulls low, zero is off
// (RULE5) rising cascade output takes new last stage on each rising edge
// (RULE6) falling cascade output takes last stage on each falling edge
// (RULE7) chain from rising output with fast clocks, falling output with slow clocks
// (RULE8) no power-on state in the chain; controller loads and strobes before enabling; here reset clears the chain and the bench enables with the strobe
`include "ssd_defs.svh"
module ssd_driver #(
    parameter int STAGES = `SSD_STAGES
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire ssd_pkg::ssd_pins_t pins,
    output ssd_pkg::ssd_sink_t led_sink_outputs,
    output logic rising_cascade_out,
    output logic falling_cascade_out
);
    import ssd_pkg::*;

    // three stage synchronisers; first stage read only by the second
    logic [`SSD_SYNC_DEPTH-1:0] sync_d_r, sync_c_r, sync_s_r, sync_e_r;
    logic [`SSD_SYNC_DEPTH-1:0] sync_d_nxt, sync_c_nxt, sync_s_nxt, sync_e_nxt;
    logic d_q_r, c_q_r, s_q_r, e_q_r;
    logic d_q_nxt, c_q_nxt, s_q_nxt, e_q_nxt;
    logic [STAGES-1:0] stage_r, stage_nxt;
    logic [STAGES-1:0] latch_r, latch_nxt;
    logic [STAGES-1:0] sink_o_r, sink_o_nxt;
    logic [STAGES-1:0] sink_oe_n_r, sink_oe_n_nxt;
    logic rco_r, rco_nxt, fco_r, fco_nxt;
    logic clk_rise, clk_fall;

    // accepted level changes only when second and third agree
    function automatic logic settle(input logic [`SSD_SYNC_DEPTH-1:0] s, input logic held);
        settle = (s[1] == s[2]) ? s[1] : held;
    endfunction

    always_comb begin
        sync_d_nxt = {sync_d_r[1:0], pins.serial_in};
        sync_c_nxt = {sync_c_r[1:0], pins.shift_clock};
        sync_s_nxt = {sync_s_r[1:0], pins.latch_strobe};
        sync_e_nxt = {sync_e_r[1:0], pins.output_enable};
        d_q_nxt = settle(sync_d_r, d_q_r);
        c_q_nxt = settle(sync_c_r, c_q_r);
        s_q_nxt = settle(sync_s_r, s_q_r);
        e_q_nxt = settle(sync_e_r, e_q_r);
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            sync_d_r <= '0;
            sync_c_r <= '0;
            sync_s_r <= '0;
            sync_e_r <= '0;
            d_q_r <= 1'b0;
            c_q_r <= 1'b0;
            s_q_r <= 1'b0;
            e_q_r <= 1'b0;
        end else begin
            sync_d_r <= sync_d_nxt;
            sync_c_r <= sync_c_nxt;
            sync_s_r <= sync_s_nxt;
            sync_e_r <= sync_e_nxt;
            d_q_r <= d_q_nxt;
            c_q_r <= c_q_nxt;
            s_q_r <= s_q_nxt;
            e_q_r <= e_q_nxt;
        end
    end

    assign clk_rise = c_q_nxt & ~c_q_r;
    assign clk_fall = ~c_q_nxt & c_q_r;

    always_comb begin
        stage_nxt = stage_r;
        latch_nxt = latch_r;
        rco_nxt = rco_r;
        fco_nxt = fco_r;
        if (clk_rise) begin
            stage_nxt = {stage_r[STAGES-2:0], d_q_r}; // see (RULE1)
            rco_nxt = stage_r[STAGES-2]; // see (RULE5)
        end
        if (clk_fall) begin
            fco_nxt = stage_r[STAGES-1]; // see (RULE6)
        end
        // latch transparent while strobe high, so it tracks new stage data
        if (s_q_r) begin
            latch_nxt = stage_nxt; // see (RULE2)
        end
        for (int i = 0; i < STAGES; i++) begin
            sink_o_nxt[i] = 1'b0;
            sink_oe_n_nxt[i] = ~(e_q_r & latch_nxt[i]); // see (RULE3) (RULE4)
        end
    end

    // reset clears the chain although the pin device has none; gives known state in sim
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            stage_r <= '0; // see (RULE8)
            latch_r <= '0;
            rco_r <= 1'b0;
            fco_r <= 1'b0;
            sink_o_r <= '0;
            sink_oe_n_r <= '1;
        end else begin
            stage_r <= stage_nxt;
            latch_r <= latch_nxt;
            rco_r <= rco_nxt;
            fco_r <= fco_nxt;
            sink_o_r <= sink_o_nxt;
            sink_oe_n_r <= sink_oe_n_nxt;
        end
    end

    assign led_sink_outputs.o = sink_o_r;
    assign led_sink_outputs.oe_n = sink_oe_n_r;
    assign rising_cascade_out = rco_r;
    assign falling_cascade_out = fco_r;

    property p_shift;
        @(posedge clk_sys) disable iff (!nrst)
        clk_rise |=> stage_r == {$past(stage_r[STAGES-2:0]), $past(d_q_r)};
    endproperty
    a_shift: assert property (p_shift) else $error("shift wrong"); // see (RULE1)

    property p_hold_stage;
        @(posedge clk_sys) disable iff (!nrst)
        !clk_rise |=> $stable(stage_r);
    endproperty
    a_hold_stage: assert property (p_hold_stage) else $error("stage moved without clock"); // see (RULE1)

    property p_latch_hold;
        @(posedge clk_sys) disable iff (!nrst)
        !s_q_r |=> $stable(latch_r);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch changed with strobe low"); // see (RULE2)

    property p_latch_follow;
        @(posedge clk_sys) disable iff (!nrst)
        s_q_r |=> latch_r == stage_r;
    endproperty
    a_latch_follow: assert property (p_latch_follow) else $error("latch not following"); // see (RULE2)

    property p_off;
        @(posedge clk_sys) disable iff (!nrst)
        !e_q_r |=> sink_oe_n_r == '1;
    endproperty
    a_off: assert property (p_off) else $error("output on while disabled"); // see (RULE3)

    property p_sink;
        @(posedge clk_sys) disable iff (!nrst)
        e_q_r |=> sink_oe_n_r == ~latch_r && sink_o_r == '0;
    endproperty
    a_sink: assert property (p_sink) else $error("sink polarity wrong"); // see (RULE4)

    sequence s_rise;
        clk_rise;
    endsequence
    property p_rco;
        @(posedge clk_sys) disable iff (!nrst)
        s_rise |=> rising_cascade_out == stage_r[STAGES-1];
    endproperty
    a_rco: assert property (p_rco) else $error("rising cascade wrong"); // see (RULE5)

    property p_fco;
        @(posedge clk_sys) disable iff (!nrst)
        clk_fall |=> falling_cascade_out == $past(stage_r[STAGES-1]) ##1 $stable(falling_cascade_out);
    endproperty
    a_fco: assert property (p_fco) else $error("falling cascade wrong"); // see (RULE6)

    // cascade outputs move only on their own edge; a stray change would skew a chain
    property p_rco_hold;
        @(posedge clk_sys) disable iff (!nrst)
        !clk_rise |=> $stable(rising_cascade_out);
    endproperty
    a_rco_hold: assert property (p_rco_hold) else $error("rising cascade moved off its edge"); // see (RULE5)

    property p_fco_hold;
        @(posedge clk_sys) disable iff (!nrst)
        !clk_fall |=> $stable(falling_cascade_out);
    endproperty
    a_fco_hold: assert property (p_fco_hold) else $error("falling cascade moved off its edge"); // see (RULE6)

    // half a shift clock later the slow output repeats the fast one
    sequence s_fall;
        clk_fall;
    endsequence
    property p_half_delay;
        @(posedge clk_sys) disable iff (!nrst)
        s_fall |=> falling_cascade_out == rising_cascade_out;
    endproperty
    a_half_delay: assert property (p_half_delay) else $error("cascade outputs disagree"); // see (RULE6)

    // an edge counts only once the two later sync flops agree
    property p_accept;
        @(posedge clk_sys) disable iff (!nrst)
        clk_rise |-> sync_c_r[1] && sync_c_r[2];
    endproperty
    a_accept: assert property (p_accept) else $error("clock edge taken unsettled"); // see (RULE1)

    // no disable here: the cleared chain is what the reset is for
    property p_reset_clear;
        @(posedge clk_sys)
        !nrst |=> stage_r == '0 && latch_r == '0 && sink_oe_n_r == '1;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("chain not cleared by reset"); // see (RULE8)

    property p_out_steady;
        @(posedge clk_sys) disable iff (!nrst)
        !s_q_r && !$past(s_q_r) && $stable(e_q_r) |=> $stable(sink_oe_n_r);
    endproperty
    a_out_steady: assert property (p_out_steady) else $error("outputs moved with strobe low"); // see (RULE2)

    // transparent latch picks up the bit entering in the same edge
    property p_latch_new_bit;
        @(posedge clk_sys) disable iff (!nrst)
        s_q_r && clk_rise |=> latch_r[0] == $past(d_q_r);
    endproperty
    a_latch_new_bit: assert property (p_latch_new_bit) else $error("latch missed new bit"); // see (RULE2)

    // open drain never drives high
    property p_sink_low;
        @(posedge clk_sys) disable iff (!nrst)
        sink_o_r == '0;
    endproperty
    a_sink_low: assert property (p_sink_low) else $error("sink output driven high"); // see (RULE4)
endmodule

/* File: verification/ssd_host_model.sv */
// host controller model driving the driver's pins
module ssd_host_model (
    input wire logic clk_sys,
    input wire logic rising_cascade_out,
    input wire logic falling_cascade_out,
    output ssd_pkg::ssd_pins_t pins
);
    timeunit 1ns;
    timeprecision 1ps;
    import ssd_pkg::*;
    // stand-ins for the next device in a chain, one fed from each cascade output
    logic [7:0] down_fast = 8'h00;
    logic [7:0] down_slow = 8'h00;
    initial pins = '0;
    task automatic hold(int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // six-cycle phases: sync needs four, two spare
    task automatic edge_to(logic lvl);
        hold(1);
        // next device clocks on this same edge, so it takes the cascade bit before it moves
        if (lvl) begin
            down_fast = {down_fast[6:0], rising_cascade_out};
            down_slow = {down_slow[6:0], falling_cascade_out};
        end
        pins.shift_clock = lvl;
        hold(6);
    endtask
    // data settles well before the rise and is held after it
    task automatic set_data(logic b);
        hold(1);
        pins.serial_in = b;
        hold(5);
    endtask
    // bench raises enable together with the strobe, before the last of the eight bits is shifted in
    task automatic set_ctl(logic stb, logic en);
        hold(1);
        pins.latch_strobe = stb;
        pins.output_enable = en;
        hold(6);
    endtask
endmodule

/* File: verification/ssd_driver_tb.sv */
// self-checking bench for the led sink driver
module ssd_driver_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ssd_pkg::*;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    ssd_pins_t pins;
    ssd_sink_t sink;
    logic rco;
    logic fco;
    logic [7:0] shadow = 8'h00;
    logic [7:0] held = 8'h00;
    int err_count = 0;
    int checks_done = 0;
    ssd_driver u_dut (.clk_sys(clk_sys), .nrst(nrst), .pins(pins), .led_sink_outputs(sink),
        .rising_cascade_out(rco), .falling_cascade_out(fco));
    ssd_host_model u_host (.clk_sys(clk_sys), .rising_cascade_out(rco), .falling_cascade_out(fco),
        .pins(pins));
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic chk(logic [7:0] seen, logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // both cascade outputs judged after each half of the shift clock
    task automatic shift_bit(logic b, logic en);
        logic [7:0] old;
        old = shadow;
        u_host.set_data(b);
        u_host.edge_to(1'b1);
        shadow = {shadow[6:0], b};
        chk({7'h00, rco}, {7'h00, old[6]});
        chk({7'h00, fco}, {7'h00, old[7]});
        u_host.edge_to(1'b0);
        chk({7'h00, fco}, {7'h00, shadow[7]});
        chk({7'h00, rco}, {7'h00, old[6]});
        if (pins.latch_strobe) held = shadow;
        chk(sink.oe_n, en ? ~held : 8'hFF);
    endtask
    // msb first, so bit i ends in stage i; strobe only around the last bit
    task automatic load(logic [7:0] v, logic en, logic stb);
        for (int i = 7; i >= 0; i--) begin
            if (i == 0 && stb) u_host.set_ctl(1'b1, en);
            shift_bit(v[i], en);
        end
        if (stb) u_host.set_ctl(1'b0, en);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge clk_sys);
        nrst = 1'b1;
        u_host.set_ctl(1'b0, 1'b0);
        load(8'hA5, 1'b0, 1'b0);
        load(8'h3C, 1'b1, 1'b1);
        chk(sink.oe_n, 8'hC3);
        load(8'h0F, 1'b1, 1'b0);
        u_host.set_ctl(1'b0, 1'b0);
        chk(sink.oe_n, 8'hFF);
        chk(sink.o, 8'h00);
        // after 24 bits the chained device holds the middle byte
        chk(u_host.down_fast, 8'h3C);
        chk(u_host.down_slow, 8'h3C);
        results();
    end
endmodule
